// [include/mahbp_regs.svh]
// Register offsets, field positions, reset values and timing constants.
`ifndef MAHBP_REGS_SVH
`define MAHBP_REGS_SVH
`define MAHBP_OFS_SRC_LO 3'h0
`define MAHBP_OFS_SRC_HI 3'h1
`define MAHBP_OFS_HASH_LO 3'h2
`define MAHBP_OFS_HASH_HI 3'h3
`define MAHBP_OFS_BOFF 3'h4
`define MAHBP_OFS_PACE 3'h5
`define MAHBP_ZERO32 32'h0000_0000
`define MAHBP_RND_LSB 16
`define MAHBP_COLL_LSB 12
`define MAHBP_PACE_LOAD 5'h1F
`define MAHBP_IPG_NS 9600
`define MAHBP_CLK_NS 100
`define MAHBP_IPG_CYC ((`MAHBP_IPG_NS + `MAHBP_CLK_NS - 1) / `MAHBP_CLK_NS)
`define MAHBP_PACE_MULT 4
`endif

// [include/mahbp_pkg.sv]
// Types shared by the address, hash, backoff and pacing block.
package mahbp_pkg;
   typedef enum logic [1:0] {
      MAHBP_IDLE = 2'h0,
      MAHBP_READY = 2'h1,
      MAHBP_GAP = 2'h3
   } mahbp_gap_t;
endpackage

// [core/mahbp_hash_filter.sv]
// Group address hash and acceptance table lookup.
`timescale 1ns/10ps
module mahbp_hash_filter (
   // Received address and table.
   input wire logic [47:0] destinationAddress,
   input wire logic [63:0] hashTable,
   // Result.
   output logic [5:0] hashIndex,
   output logic groupAccept
);
   function automatic logic [5:0] foldHash(input logic [47:0] addr);
      logic [5:0] h;
      h = 6'h00;
      for (int k = 0; k < 8; k++) begin
         h = h ^ addr[k*6 +: 6];
      end
      return h;
   endfunction
   assign hashIndex = foldHash(destinationAddress);
   assign groupAccept = hashTable[hashIndex];
endmodule

// [core/mahbp_backoff.sv]
// Backoff random generator, collision count and slot backoff counter.
`timescale 1ns/10ps
module mahbp_backoff #(
   parameter int RND_W = 10,
   parameter int COLL_W = 4
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Transmit events.
   input wire logic txCollision,
   input wire logic txFrameDone,
   input wire logic slotTick,
   // Observed values.
   output logic [RND_W-1:0] backoffRandomValue,
   output logic [COLL_W-1:0] frameCollisionCount,
   output logic [RND_W-1:0] backoffSlotCounter
);
   logic [RND_W-1:0] rnd_r;
   logic [COLL_W-1:0] coll_r;
   logic [RND_W-1:0] boff_r;
   logic [COLL_W-1:0] collInc;
   logic [RND_W-1:0] loadMask;
   logic [RND_W-1:0] boff_nxt;
   function automatic logic [RND_W-1:0] expMask(input logic [COLL_W-1:0] n);
      logic [RND_W-1:0] m;
      m = '0;
      for (int k = 0; k < RND_W; k++) begin
         if (k < int'(n)) begin
            m[k] = 1'b1;
         end
      end
      return m;
   endfunction
   assign collInc = (coll_r == '1) ? coll_r : coll_r + 1'b1;
   assign loadMask = expMask(collInc);
   assign boff_nxt = txCollision ? (rnd_r & loadMask) :
      ((slotTick && boff_r != '0) ? boff_r - 1'b1 : boff_r);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rnd_r <= '0;
         coll_r <= '0;
         boff_r <= '0;
      end else begin
         rnd_r <= rnd_r + 1'b1;
         coll_r <= txCollision ? collInc : (txFrameDone ? '0 : coll_r);
         boff_r <= boff_nxt;
      end
   end
   assign backoffRandomValue = rnd_r;
   assign frameCollisionCount = coll_r;
   assign backoffSlotCounter = boff_r;
endmodule

// [core/mac_addr_hash_backoff_pacing.sv]
// Station address, group hash filter, backoff status and transmit pacing.
// Summary of operation
// - Low address register holds bytes zero, one.
// - High address register holds bytes two to five.
// - Hash bit i XORs every sixth address bit.
// - Accept group frame when indexed table bit set.
// - Two writable hash registers, values 0-31, 32-63.
// - Free running random counter, zero at reset.
// - Read-only collision count of current frame.
// - Backoff counter loads on collision, decrements per slot.
// - Pacing loads 31 on collision or deferral.
// - Good frame decrements pacing, stopping at zero.
// - Pacing active: four gaps after good frame.
// - After deferred or collided frame: normal gap.
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "mahbp_regs.svh"
module mac_addr_hash_backoff_pacing #(
   parameter int IPG_CYC = `MAHBP_IPG_CYC,
   parameter int GAP_W = 16
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Avalon-MM slave.
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Receive filter.
   input wire logic [47:0] destinationAddress,
   input wire logic rxGroupFrame,
   output logic rxGroupAccept,
   output logic [47:0] stationAddress,
   // Transmit events.
   input wire logic txCollision,
   input wire logic txDeferred,
   input wire logic txGoodDone,
   input wire logic slotTick,
   // Transmit gap control.
   output logic txGapDone,
   output logic pacingActive
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] srcLo_r;
   logic [31:0] srcHi_r;
   logic [31:0] hashLo_r;
   logic [31:0] hashHi_r;
   logic [4:0] pace_r;
   logic [4:0] pace_nxt;
   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic lastBad_r;
   mahbp_pkg::mahbp_gap_t gap_r;
   mahbp_pkg::mahbp_gap_t gap_nxt;
   logic [GAP_W-1:0] gapCnt_r;
   logic [GAP_W-1:0] gapCnt_nxt;
   logic [9:0] rndVal;
   logic [3:0] collCnt;
   logic [9:0] boffCnt;
   logic [5:0] hashIdx;
   logic hashHit;
   logic frameEnd;
   logic badFrame;
   logic [GAP_W-1:0] gapLen;
   wire wrSrcLo = avs_write && ack_r && avs_address == `MAHBP_OFS_SRC_LO;
   wire wrSrcHi = avs_write && ack_r && avs_address == `MAHBP_OFS_SRC_HI;
   wire wrHashLo = avs_write && ack_r && avs_address == `MAHBP_OFS_HASH_LO;
   wire wrHashHi = avs_write && ack_r && avs_address == `MAHBP_OFS_HASH_HI;
   function automatic logic [31:0] byteMerge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction
   wire [31:0] srcLoMerge = byteMerge({16'h0000, srcLo_r}, avs_writedata, avs_byteenable);
   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   mahbp_hash_filter uHash (
      .destinationAddress(destinationAddress),
      .hashTable({hashHi_r, hashLo_r}),
      .hashIndex(hashIdx),
      .groupAccept(hashHit)
   );
   mahbp_backoff #(.RND_W(10), .COLL_W(4)) uBoff (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .txCollision(txCollision),
      .txFrameDone(txGoodDone | txDeferred),
      .slotTick(slotTick),
      .backoffRandomValue(rndVal),
      .frameCollisionCount(collCnt),
      .backoffSlotCounter(boffCnt)
   );
   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   always_comb begin
      rdata_nxt = `MAHBP_ZERO32;
      case (avs_address)
         `MAHBP_OFS_SRC_LO: rdata_nxt = {16'h0000, srcLo_r};
         `MAHBP_OFS_SRC_HI: rdata_nxt = srcHi_r;
         `MAHBP_OFS_HASH_LO: rdata_nxt = hashLo_r;
         `MAHBP_OFS_HASH_HI: rdata_nxt = hashHi_r;
         `MAHBP_OFS_BOFF: begin
            rdata_nxt[`MAHBP_RND_LSB +: 10] = rndVal;
            rdata_nxt[`MAHBP_COLL_LSB +: 4] = collCnt;
            rdata_nxt[9:0] = boffCnt;
         end
         `MAHBP_OFS_PACE: rdata_nxt = {27'h0000000, pace_r};
         default: rdata_nxt = `MAHBP_ZERO32;
      endcase
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
         rdata_r <= `MAHBP_ZERO32;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         rdata_r <= rdata_nxt;
      end
   end
   assign avs_readdata = rdata_r;
   // ----------------------------------------
   // Address and hash registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         srcLo_r <= 16'h0000;
         srcHi_r <= `MAHBP_ZERO32;
         hashLo_r <= `MAHBP_ZERO32;
         hashHi_r <= `MAHBP_ZERO32;
      end else begin
         if (wrSrcLo) begin
            srcLo_r <= srcLoMerge[15:0];
         end
         if (wrSrcHi) begin
            srcHi_r <= byteMerge(srcHi_r, avs_writedata, avs_byteenable);
         end
         if (wrHashLo) begin
            hashLo_r <= byteMerge(hashLo_r, avs_writedata, avs_byteenable);
         end
         if (wrHashHi) begin
            hashHi_r <= byteMerge(hashHi_r, avs_writedata, avs_byteenable);
         end
      end
   end
   assign stationAddress = {srcHi_r[7:0], srcHi_r[15:8], srcHi_r[23:16],
      srcHi_r[31:24], srcLo_r[7:0], srcLo_r[15:8]};
   assign rxGroupAccept = rxGroupFrame & hashHit;
   // ----------------------------------------
   // Transmit pacing
   // ----------------------------------------
   assign badFrame = txCollision | txDeferred;
   assign frameEnd = txGoodDone | txDeferred;
   assign pace_nxt = badFrame ? `MAHBP_PACE_LOAD :
      ((txGoodDone && pace_r != 5'h00) ? pace_r - 5'h01 : pace_r);
   assign gapLen = (!lastBad_r && pace_r != 5'h00 && !txDeferred) ?
      GAP_W'(IPG_CYC * `MAHBP_PACE_MULT) : GAP_W'(IPG_CYC);
   always_comb begin
      gap_nxt = gap_r;
      gapCnt_nxt = gapCnt_r;
      case (gap_r)
         mahbp_pkg::MAHBP_IDLE: begin
            gap_nxt = mahbp_pkg::MAHBP_READY;
         end
         mahbp_pkg::MAHBP_READY: begin
            if (frameEnd) begin
               gap_nxt = mahbp_pkg::MAHBP_GAP;
               gapCnt_nxt = gapLen - GAP_W'(1);
            end
         end
         mahbp_pkg::MAHBP_GAP: begin
            if (gapCnt_r == '0) begin
               gap_nxt = mahbp_pkg::MAHBP_READY;
            end else begin
               gapCnt_nxt = gapCnt_r - GAP_W'(1);
            end
         end
         default: gap_nxt = mahbp_pkg::MAHBP_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pace_r <= 5'h00;
         lastBad_r <= 1'b0;
         gap_r <= mahbp_pkg::MAHBP_IDLE;
         gapCnt_r <= '0;
      end else begin
         pace_r <= pace_nxt;
         if (txCollision) begin
            lastBad_r <= 1'b1;
         end else if (frameEnd) begin
            lastBad_r <= 1'b0;
         end
         gap_r <= gap_nxt;
         gapCnt_r <= gapCnt_nxt;
      end
   end
   assign txGapDone = (gap_r == mahbp_pkg::MAHBP_READY);
   assign pacingActive = (pace_r != 5'h00);
endmodule

// [testbench/mahbp_chk.sv]
// Checker for the gap, pacing, filter and bus timing.
`timescale 1ns/10ps
`include "mahbp_regs.svh"
module mahbp_chk #(
   parameter int IPG_CYC = `MAHBP_IPG_CYC
) (
   // Clock, reset and bus.
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   // Filter and address.
   input wire logic rxGroupFrame,
   input wire logic rxGroupAccept,
   input wire logic [47:0] stationAddress,
   // Transmit.
   input wire logic txCollision,
   input wire logic txDeferred,
   input wire logic txGoodDone,
   input wire logic txGapDone,
   input wire logic pacingActive
);
   logic hadEvt_r;
   localparam int GAP_N = IPG_CYC;
   localparam int STR_END = IPG_CYC * `MAHBP_PACE_MULT + 1;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) hadEvt_r <= 1'b0;
      else if (txCollision) hadEvt_r <= 1'b1;
      else if (txGoodDone || txDeferred) hadEvt_r <= 1'b0;
   end
   AST_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   AST_ACCEPT: assert property (!rxGroupFrame |-> !rxGroupAccept)
      else $error("accept without group frame");
   AST_STATION: assert property (!avs_write |=> $stable(stationAddress))
      else $error("station address moved");
   AST_PACE_COL: assert property (txCollision |=> pacingActive)
      else $error("pacing not loaded");
   AST_PACE_DEF: assert property (txDeferred |=> pacingActive)
      else $error("pacing not loaded");
   AST_PACE_ZERO: assert property (!pacingActive && !txCollision && !txDeferred |=> !pacingActive)
      else $error("pacing left zero");
   AST_STRETCH: assert property (txGoodDone && pacingActive && !hadEvt_r |=> !txGapDone [*8])
      else $error("gap not stretched");
   AST_STRETCH_END: assert property (
      txGoodDone && pacingActive && !hadEvt_r |-> ##[STR_END:STR_END] txGapDone)
      else $error("stretched gap too long");
   AST_SHORT: assert property (
      txDeferred || (txGoodDone && hadEvt_r) |=> !txGapDone ##[GAP_N:GAP_N] txGapDone)
      else $error("normal gap wrong");
   AST_PLAIN: assert property (
      txGoodDone && !pacingActive |=> !txGapDone ##[GAP_N:GAP_N] txGapDone)
      else $error("plain gap wrong");
endmodule
bind mac_addr_hash_backoff_pacing mahbp_chk #(.IPG_CYC(IPG_CYC)) u_chk (.*);

// [testbench/mahbp_phy_model.sv]
// Far side model sending transmit outcomes and slot ticks.
`timescale 1ns/10ps
module mahbp_phy_model (
   // Clock and gap status.
   input wire logic ref_clk,
   input wire logic txGapDone,
   // Outcomes.
   output logic txCollision,
   output logic txDeferred,
   output logic txGoodDone,
   output logic slotTick
);
   logic [2:0] slotCnt_r = 3'h0;
   initial {txCollision, txDeferred, txGoodDone} = 3'h0;
   assign slotTick = (slotCnt_r == 3'h7);
   always @(posedge ref_clk) slotCnt_r <= slotCnt_r + 3'h1;
   task frame(input int kind, input int idle);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (txGapDone !== 1'b1 && n < 500) begin
         @(negedge ref_clk);
         n++;
      end
      repeat (idle + 1) @(posedge ref_clk);
      {txCollision, txDeferred, txGoodDone} <= 3'h4 >> kind;
      @(posedge ref_clk);
      {txCollision, txDeferred, txGoodDone} <= 3'h0;
   endtask
endmodule

// [testbench/tb.sv]
// Self-checking testbench for the address, hash, backoff and pacing block.
`timescale 1ns/10ps
module tb;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] avs_address = 3'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [47:0] destinationAddress = 48'h0;
   logic rxGroupFrame = 1'b0;
   logic [31:0] avs_readdata, rdq, wd;
   logic [47:0] stationAddress;
   logic [63:0] tbl, m;
   logic [63:0] expQ[$];
   logic avs_waitrequest, rxGroupAccept, txCollision, txDeferred, txGoodDone, slotTick;
   logic txGapDone, pacingActive, wrq, h;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 6;
   localparam int IPG = 4;
   always #50 ref_clk = ~ref_clk;
   mac_addr_hash_backoff_pacing #(.IPG_CYC(IPG)) u_dut (.*);
   mahbp_phy_model u_phy (.ref_clk(ref_clk), .txGapDone(txGapDone), .txCollision(txCollision),
      .txDeferred(txDeferred), .txGoodDone(txGoodDone), .slotTick(slotTick));
   task chk(input string n, input logic [47:0] e, input logic [47:0] s);
      comparisons++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrap_up();
      $display("Compared %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task gap(input int e, input logic p);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (txGapDone !== 1'b1) begin
         @(negedge ref_clk);
         n++;
      end
      chk("gap", 48'(e), 48'(n));
      chk("pacing", {47'h0, p}, {47'h0, pacingActive});
      @(posedge ref_clk);
   endtask
   task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      do @(posedge ref_clk); while (wrq !== 1'b0);
      {avs_write, avs_read} <= 2'h0;
      @(posedge ref_clk);
   endtask
   task rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] k);
      expQ.push_back({k, e});
      bus(1'b0, a, 32'h0000_0000);
   endtask
   always @(negedge ref_clk) {wrq, rdq} = {avs_waitrequest, avs_readdata};
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
      if (avs_read && !wrq) begin
         m = expQ.pop_front();
         chk("readdata", {16'h0, m[31:0]}, {16'h0, rdq & m[63:32]});
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      for (int a = 0; a < 8; a++) rd(a[2:0], a == 4 ? 32'h000D_0000 : 32'h0, 32'hFFFF_FFFF);
      wd = $random(seed);
      bus(1'b1, 3'h0, wd);
      rd(3'h0, {16'h0, wd[15:0]}, 32'hFFFF_FFFF);
      chk("station low", {wd[7:0], wd[15:8]}, stationAddress[15:0]);
      wd = $random(seed);
      bus(1'b1, 3'h1, wd);
      rd(3'h1, wd, 32'hFFFF_FFFF);
      chk("station high", {wd[7:0], wd[15:8], wd[23:16], wd[31:24]}, stationAddress[47:16]);
      tbl = {$random(seed), $random(seed)};
      bus(1'b1, 3'h2, tbl[31:0]);
      bus(1'b1, 3'h3, tbl[63:32]);
      wd = ~tbl[31:0];
      avs_byteenable <= 4'h5;
      bus(1'b1, 3'h2, wd);
      avs_byteenable <= 4'hF;
      tbl[23:16] = wd[23:16];
      tbl[7:0] = wd[7:0];
      rd(3'h2, tbl[31:0], 32'hFFFF_FFFF);
      rd(3'h3, tbl[63:32], 32'hFFFF_FFFF);
      for (int i = 0; i < 64; i++) begin
         m = {$random(seed), $random(seed)};
         destinationAddress <= m[47:0];
         rxGroupFrame <= (i % 4 != 0);
         @(posedge ref_clk);
         m = 6'h0;
         for (int j = 0; j < 48; j++) m[j % 6] = m[j % 6] ^ destinationAddress[j];
         h = rxGroupFrame & tbl[m[5:0]];
         chk("accept", {47'h0, h}, {47'h0, rxGroupAccept});
      end
      bus(1'b1, 3'h5, 32'hFFFF_FFFF);
      bus(1'b1, 3'h4, 32'hFFFF_FFFF);
      rd(3'h5, 32'h0, 32'hFFFF_FFFF);
      u_phy.frame(2, 0);
      gap(IPG, 1'b0);
      u_phy.frame(0, 3);
      rd(3'h4, 32'h0000_1000, 32'hFC00_FFFE);
      rd(3'h5, 32'h1F, 32'hFFFF_FFFF);
      for (int i = 0; i < 3; i++) u_phy.frame(0, i);
      rd(3'h4, 32'h0000_4000, 32'hFC00_FFF0);
      repeat (160) @(posedge ref_clk);
      rd(3'h4, 32'h0000_4000, 32'hFC00_FFFF);
      u_phy.frame(2, 1);
      gap(IPG, 1'b1);
      rd(3'h5, 32'h1E, 32'hFFFF_FFFF);
      rd(3'h4, 32'h0, 32'hFC00_F000);
      u_phy.frame(2, 0);
      gap(4 * IPG, 1'b1);
      u_phy.frame(1, 2);
      gap(IPG, 1'b1);
      rd(3'h5, 32'h1F, 32'hFFFF_FFFF);
      u_phy.frame(2, 0);
      gap(4 * IPG, 1'b1);
      rd(3'h5, 32'h1E, 32'hFFFF_FFFF);
      wrap_up();
   end
endmodule
